// [cci_card_cmd.sv]
// Command interpreter of a contactless memory card
//
// Overview of operation
// (R1) Config command: code 43h, type 01h strong or 00h normal, CRC.
// (R2) After reset the stored setting is strong modulation.
// (R3) New setting becomes active only after unselect or field reset.
// (R4) Setting may be rewritten any number of times, never locked.
// (R5) Config executes only when authenticated to sector 0 with first key type.
// (R6) Block 0 status byte reads 20h for strong, 00h for normal.
// (R7) Auth part one: code 60h or 61h, block address, CRC.
// (R8) Auth answers 4-byte challenge, takes 8-byte token, returns 4-byte token.
// (R9) Auth replies not before n=9 delay; part one NAK exactly at n=9.
// (R10) No upper limit on gap between auth parts.
// (R11) Block address is a full byte, 00h to FFh.
// (R12) Read 30h with address and CRC returns 16 bytes or NAK.
// (R13) Read reply not before n=9 delay.
// (R14) Write A0h with address acked, then 16 data bytes stored.
// (R15) Both write parts reply not before n=9 delay.
// (R16) Write part two accepted after any gap.
// (R17) Reader feeds last-cascade identifier bytes to cipher.
// (R18) ACK accepted parts, NAK rejected ones; CRC checked first.
// (R19) Unauthorised config gets NAK and setting is not stored.
`timescale 1ns/100ps
`include "cci_params.svh"
module cci_card_cmd (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Link state
	input wire logic fieldReset,
	input wire logic unselect,
	// Received frame bytes
	input wire logic rxValid,
	input wire cci_pkg::cci_rx_s rxByte,
	// Reply stream
	output cci_pkg::cci_tx_s txByte,
	output logic txValid,
	// Cipher engine
	output logic authStart,
	output logic authKeyB,
	output logic [7:0] authBlock,
	input wire logic [7:0] chalByte,
	input wire logic tokenOk,
	input wire logic [7:0] tokenByte,
	// Block memory
	output logic memRead,
	output logic memWrite,
	output logic [7:0] memAddr,
	output logic [127:0] memWdata,
	input wire logic [127:0] memRdata,
	input wire logic memDone,
	// Active modulation
	output logic strongMod
);
	cci_pkg::cci_state_e state_reg;
	cci_pkg::cci_reply_e reply_reg;
	logic [7:0] cmd_reg;
	logic [4:0] cnt_reg;
	logic [7:0] delay_reg;
	logic [127:0] buf_reg;
	logic authed_reg;
	logic authKeyB_reg;
	logic [7:0] authBlk_reg;
	logic modStored_reg;
	logic lastOk;
	logic frameOk;
	logic modCfgOk;
	logic authOpen;
	logic authDone;
	logic readGo;
	logic addrGo;
	logic writeGo;
	logic [4:0] replyLen;
	logic [7:0] replyData;
	// ****************************************
	// Receive decode
	// ****************************************
	assign lastOk = rxValid && rxByte.last && rxByte.crcOk; // R18
	// Commands are code plus one argument byte; a longer frame is refused
	assign frameOk = state_reg == cci_pkg::ST_RX && lastOk && cnt_reg == 5'd0;
	assign authOpen = frameOk && (cmd_reg == `CCI_CODE_AUTH_A || cmd_reg == `CCI_CODE_AUTH_B); // R7
	assign authDone = state_reg == cci_pkg::ST_AUTH2 && lastOk && tokenOk
		&& cnt_reg == 5'(`CCI_TOKEN_IN_BYTES - 1); // R8
	assign readGo = frameOk && cmd_reg == `CCI_CODE_READ && authed_reg; // R12
	assign addrGo = frameOk && cmd_reg == `CCI_CODE_WRITE && authed_reg; // R14
	assign writeGo = state_reg == cci_pkg::ST_WRDATA && lastOk && cnt_reg == 5'(`CCI_BLOCK_BYTES - 1); // R14
	// Sector access bits deliberately ignored; only key type and sector number
	assign modCfgOk = frameOk && cmd_reg == `CCI_CODE_MODCFG && authed_reg && !authKeyB_reg
		&& authBlk_reg[7:2] == 6'h00 && rxByte.data[7:1] == 7'h00 && !fieldReset && !unselect; // R5 R19
	always_comb begin
		case (reply_reg)
			cci_pkg::RP_CHAL: replyLen = 5'(`CCI_CHAL_BYTES);
			cci_pkg::RP_TOKEN: replyLen = 5'(`CCI_TOKEN_OUT_BYTES);
			cci_pkg::RP_BLOCK: replyLen = 5'(`CCI_BLOCK_BYTES);
			default: replyLen = 5'd1;
		endcase
	end
	always_comb begin
		case (reply_reg)
			cci_pkg::RP_ACK: replyData = {4'h0, `CCI_ACK}; // R18
			cci_pkg::RP_NAK: replyData = {4'h0, `CCI_NAK};
			cci_pkg::RP_CHAL: replyData = chalByte; // R8
			cci_pkg::RP_TOKEN: replyData = tokenByte;
			cci_pkg::RP_BLOCK: replyData = buf_reg[cnt_reg[3:0]*8 +: 8]; // R12
			default: replyData = 8'h00;
		endcase
	end
	// ****************************************
	// Stored and active modulation setting
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst) begin
			modStored_reg <= 1'b1; // R2
			strongMod <= 1'b1;
		end else begin
			if (modCfgOk) begin // R5 R19
				modStored_reg <= (rxByte.data == `CCI_MOD_STRONG); // R1 R4
			end
			if (fieldReset || unselect) begin
				strongMod <= modStored_reg; // R3
			end
		end
	end
	// ****************************************
	// Authentication state
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst || fieldReset || unselect) begin
			authed_reg <= 1'b0;
			authKeyB_reg <= 1'b0;
			authBlk_reg <= 8'h00;
			authStart <= 1'b0;
			authKeyB <= 1'b0;
			authBlock <= 8'h00;
		end else begin
			authStart <= 1'b0;
			// A new part one drops any earlier authentication
			if (authOpen) begin // R7
				authStart <= 1'b1;
				authKeyB <= (cmd_reg == `CCI_CODE_AUTH_B);
				authBlock <= rxByte.data; // R11
				authKeyB_reg <= (cmd_reg == `CCI_CODE_AUTH_B);
				authBlk_reg <= rxByte.data;
				authed_reg <= 1'b0;
			end
			if (authDone) begin // R8
				authed_reg <= 1'b1;
			end
		end
	end
	// ****************************************
	// Block memory requests
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst || fieldReset || unselect) begin
			memRead <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= 8'h00;
			memWdata <= '0;
		end else begin
			memRead <= readGo; // R12
			memWrite <= writeGo; // R14
			if (readGo || addrGo) begin
				memAddr <= rxByte.data; // R11
			end
			if (writeGo) begin
				memWdata <= {rxByte.data, buf_reg[119:0]};
			end
		end
	end
	// ****************************************
	// Command sequencer
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rst || fieldReset || unselect) begin
			state_reg <= cci_pkg::ST_IDLE;
			reply_reg <= cci_pkg::RP_NAK;
			cmd_reg <= 8'h00;
			cnt_reg <= 5'd0;
			delay_reg <= 8'h00;
			buf_reg <= '0;
			txValid <= 1'b0;
			txByte <= '0;
		end else begin
			txValid <= 1'b0;
			case (state_reg)
				cci_pkg::ST_IDLE: begin
					cnt_reg <= 5'd0;
					if (rxValid) begin
						cmd_reg <= rxByte.data;
						state_reg <= cci_pkg::ST_RX;
						// A one-byte frame carries no argument and is refused at once
						if (rxByte.last) begin
							delay_reg <= 8'h00;
							reply_reg <= cci_pkg::RP_NAK; // R18
							state_reg <= cci_pkg::ST_WAITREPLY;
						end
					end
				end
				cci_pkg::ST_RX: begin
					if (rxValid) begin
						cnt_reg <= cnt_reg + 5'd1;
						if (rxByte.last) begin
							delay_reg <= 8'h00;
							state_reg <= cci_pkg::ST_WAITREPLY;
							reply_reg <= cci_pkg::RP_NAK; // R18
							if (frameOk) begin
								case (cmd_reg)
									`CCI_CODE_AUTH_A, `CCI_CODE_AUTH_B: begin // R7
										reply_reg <= cci_pkg::RP_CHAL; // R8
									end
									`CCI_CODE_READ: begin
										if (readGo) begin
											reply_reg <= cci_pkg::RP_BLOCK; // R12
											state_reg <= cci_pkg::ST_MEMWAIT;
										end
									end
									`CCI_CODE_WRITE: begin
										if (addrGo) begin
											reply_reg <= cci_pkg::RP_ACK; // R14
										end
									end
									`CCI_CODE_MODCFG: begin
										if (modCfgOk) begin // R5 R19
											reply_reg <= cci_pkg::RP_ACK;
										end
									end
									default: reply_reg <= cci_pkg::RP_NAK;
								endcase
							end
						end
					end
				end
				cci_pkg::ST_MEMWAIT: begin
					// Delay keeps counting so the frame delay is met from end of frame
					if (delay_reg != 8'hFF) begin
						delay_reg <= delay_reg + 8'h01;
					end
					if (memDone) begin
						buf_reg <= memRdata;
						if (memAddr == 8'h00) begin
							buf_reg[`CCI_STATUS_BYTE*8 +: 8] <= modStored_reg ? `CCI_STATUS_STRONG
								: `CCI_STATUS_NORMAL; // R6
						end
						state_reg <= cci_pkg::ST_WAITREPLY;
					end
				end
				cci_pkg::ST_WAITREPLY: begin
					if (delay_reg != 8'hFF) begin
						delay_reg <= delay_reg + 8'h01;
					end
					// Reply held to exactly n=9 so NAK timing is deterministic
					if (delay_reg >= 8'(`CCI_FDT_CYC - 1)) begin // R9 R13 R15
						cnt_reg <= 5'd0;
						state_reg <= cci_pkg::ST_SEND;
					end
				end
				cci_pkg::ST_SEND: begin
					txValid <= 1'b1;
					txByte.isNibble <= (reply_reg == cci_pkg::RP_ACK || reply_reg == cci_pkg::RP_NAK);
					txByte.last <= (cnt_reg == replyLen - 5'd1);
					txByte.data <= replyData; // R18
					cnt_reg <= cnt_reg + 5'd1;
					if (cnt_reg == replyLen - 5'd1) begin
						cnt_reg <= 5'd0;
						state_reg <= cci_pkg::ST_IDLE;
						if (reply_reg == cci_pkg::RP_CHAL) begin
							state_reg <= cci_pkg::ST_AUTH2; // R10
						end
						if (reply_reg == cci_pkg::RP_ACK && cmd_reg == `CCI_CODE_WRITE) begin
							state_reg <= cci_pkg::ST_WRDATA; // R16
						end
					end
				end
				cci_pkg::ST_AUTH2: begin
					// No timeout here: the reader may wait as long as it likes
					if (rxValid) begin
						cnt_reg <= cnt_reg + 5'd1;
						if (rxByte.last) begin
							delay_reg <= 8'h00;
							state_reg <= cci_pkg::ST_WAITREPLY;
							if (authDone) begin // R8 R18
								reply_reg <= cci_pkg::RP_TOKEN;
							end else begin
								reply_reg <= cci_pkg::RP_NAK;
							end
						end
					end
				end
				cci_pkg::ST_WRDATA: begin
					if (rxValid) begin
						buf_reg[cnt_reg[3:0]*8 +: 8] <= rxByte.data;
						cnt_reg <= cnt_reg + 5'd1;
						if (rxByte.last) begin
							delay_reg <= 8'h00;
							state_reg <= cci_pkg::ST_WAITREPLY;
							reply_reg <= cci_pkg::RP_NAK;
							// Closing the data phase keeps its ACK from reopening it
							cmd_reg <= 8'h00;
							if (writeGo) begin // R14
								reply_reg <= cci_pkg::RP_ACK;
							end
						end
					end
				end
				default: state_reg <= cci_pkg::ST_IDLE;
			endcase
		end
	end
endmodule : cci_card_cmd

// [cci_params.svh]
// Constants of the card command interpreter
`ifndef CCI_PARAMS_SVH
`define CCI_PARAMS_SVH
`define CCI_CODE_MODCFG 8'h43
`define CCI_CODE_AUTH_A 8'h60
`define CCI_CODE_AUTH_B 8'h61
`define CCI_CODE_READ 8'h30
`define CCI_CODE_WRITE 8'hA0
`define CCI_MOD_STRONG 8'h01
`define CCI_MOD_NORMAL 8'h00
`define CCI_STATUS_STRONG 8'h20
`define CCI_STATUS_NORMAL 8'h00
`define CCI_ACK 4'hA
`define CCI_NAK 4'h0
`define CCI_BLOCK_BYTES 16
`define CCI_CHAL_BYTES 4
`define CCI_TOKEN_IN_BYTES 8
`define CCI_TOKEN_OUT_BYTES 4
`define CCI_STATUS_BYTE 8
// Frame delay n=9 in carrier periods (1/13.56 MHz): (n*128+20)
`define CCI_FDT_NS 1_000
`define CCI_CLK_NS 50
`define CCI_FDT_CYC ((`CCI_FDT_NS + `CCI_CLK_NS - 1) / `CCI_CLK_NS)
`endif

// [cci_pkg.sv]
// Types of the card command interpreter
package cci_pkg;
	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic crcOk;
	} cci_rx_s;
	typedef struct packed {
		logic isNibble;
		logic [7:0] data;
		logic last;
	} cci_tx_s;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_RX = 4'b0001,
		ST_WAITREPLY = 4'b0010,
		ST_SEND = 4'b0011,
		ST_AUTH2 = 4'b0100,
		ST_WRDATA = 4'b0101,
		ST_MEMWAIT = 4'b0110
	} cci_state_e;
	typedef enum logic [2:0] {
		RP_ACK = 3'b000,
		RP_NAK = 3'b001,
		RP_CHAL = 3'b010,
		RP_TOKEN = 3'b011,
		RP_BLOCK = 3'b100
	} cci_reply_e;
endpackage : cci_pkg

// [cci_card_chk.sv]
// Assertion checker of the card command interpreter
`timescale 1ns/100ps
`include "cci_params.svh"
module cci_card_chk (
	// Clock and reset
	input logic core_clk,
	input logic rst,
	// Watched ports
	input logic fieldReset,
	input logic unselect,
	input logic rxValid,
	input cci_pkg::cci_rx_s rxByte,
	input cci_pkg::cci_tx_s txByte,
	input logic txValid,
	input logic authStart,
	input logic memRead,
	input logic memWrite,
	input logic strongMod
);
	// ****
	// Helpers
	// ****
	logic [5:0] gapReg;
	logic [4:0] cntReg;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// Saturates so long idle gaps stay legal
	always_ff @(posedge core_clk) begin
		if (rst || (rxValid && rxByte.last)) gapReg <= 6'h00;
		else if (gapReg != 6'h3F) gapReg <= gapReg + 6'h01;
	end
	always_ff @(posedge core_clk) begin
		if (rst || fieldReset || unselect || (txValid && txByte.last)) cntReg <= 5'h00;
		else if (txValid) cntReg <= cntReg + 5'h01;
	end
	a_reset_state: assert property ($fell(rst) |-> strongMod && !txValid && !memRead && !authStart)
		else $error("bad state after reset");
	a_reply_gap: assert property (txValid && cntReg == 5'h00 |-> gapReg >= 6'h13)
		else $error("reply before frame delay");
	a_crc_nak: assert property (rxValid && rxByte.last && !rxByte.crcOk |->
		##[20:22] txValid && txByte.isNibble && txByte.data[3:0] == `CCI_NAK) else $error("no nak on bad crc");
	a_mod_hold: assert property ($changed(strongMod) |-> $past(fieldReset) || $past(unselect) || $past(rst))
		else $error("modulation changed early");
	a_reply_len: assert property (txValid && txByte.last |->
		(txByte.isNibble ? cntReg == 5'h00 : (cntReg == 5'h03 || cntReg == 5'h0F))) else $error("bad reply length");
	a_tx_burst: assert property (txValid && !txByte.last && !fieldReset && !unselect |=> txValid)
		else $error("gap inside reply");
	a_nibble_code: assert property (txValid && txByte.isNibble |->
		txByte.last && txByte.data[3:0] inside {`CCI_ACK, `CCI_NAK}) else $error("bad nibble reply");
	a_mem_single: assert property (memWrite |-> !memRead)
		else $error("read and write together");
	cover property (txValid && txByte.last && cntReg == 5'h0F);
	cover property ($fell(strongMod));
	cover property (memWrite);
endmodule : cci_card_chk
bind cci_card_cmd cci_card_chk u_cci_card_chk (.core_clk, .rst, .fieldReset, .unselect, .rxValid, .rxByte,
	.txByte, .txValid, .authStart, .memRead, .memWrite, .strongMod);

// [cci_card_peer.sv]
// Memory and cipher stand-in facing the command interpreter
`timescale 1ns/100ps
module cci_card_peer (
	// Clock
	input logic core_clk,
	// Requests
	input logic authStart,
	input logic memRead,
	input logic memWrite,
	input logic [7:0] memAddr,
	input logic [127:0] memWdata,
	// Answers
	output logic [7:0] chalByte,
	output logic tokenOk,
	output logic [7:0] tokenByte,
	output logic [127:0] memRdata,
	output logic memDone
);
	// ****
	// Model
	// ****
	logic [127:0] mem [256];
	logic [1:0] waitReg;
	initial begin
		foreach (mem[i]) mem[i] = {16{8'(i)}};
		chalByte = 8'hC3;
		memRdata = '0;
		memDone = 1'b0;
		waitReg = 2'h0;
	end
	// Reader is taken to key the cipher with the last-cascade identifier
	assign tokenOk = 1'b1;
	assign tokenByte = ~chalByte;
	// Moving challenge exposes stale sampling
	always @(posedge core_clk) chalByte <= authStart ? 8'hC3 : {chalByte[6:0], chalByte[7] ^ chalByte[5]};
	// Fixed latency; data scrambled outside the answer cycle
	always @(posedge core_clk) begin
		if (memRead || memWrite) waitReg <= 2'h3;
		else if (waitReg != 2'h0) waitReg <= waitReg - 2'h1;
		if (memWrite) mem[memAddr] <= memWdata;
		memDone <= waitReg == 2'h1;
		memRdata <= waitReg == 2'h1 ? mem[memAddr] : ~memRdata;
	end
endmodule : cci_card_peer

// [cci_card_tb.sv]
// Self-checking bench of the card command interpreter
`timescale 1ns/100ps
`include "cci_params.svh"
module testbench;
	// ****
	// Harness
	// ****
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic fieldReset = 1'b0;
	logic unselect = 1'b0;
	logic rxValid = 1'b0;
	cci_pkg::cci_rx_s rxByte = '0;
	cci_pkg::cci_tx_s txByte;
	logic txValid, authStart, authKeyB, memRead, memWrite, memDone, tokenOk, strongMod;
	logic [7:0] authBlock, memAddr, chalByte, tokenByte;
	logic [127:0] memWdata, memRdata;
	logic [7:0] r[$];
	logic [7:0] d[$];
	int nMismatch = 0;
	int testsRun = 0;
	always #25 core_clk = ~core_clk;
	cci_card_cmd u_cci_card_cmd (.core_clk, .rst, .fieldReset, .unselect, .rxValid, .rxByte, .txByte, .txValid,
		.authStart, .authKeyB, .authBlock, .chalByte, .tokenOk, .tokenByte, .memRead, .memWrite, .memAddr,
		.memWdata, .memRdata, .memDone, .strongMod);
	cci_card_peer u_cci_card_peer (.core_clk, .authStart, .memRead, .memWrite, .memAddr, .memWdata, .chalByte,
		.tokenOk, .tokenByte, .memRdata, .memDone);
	task finalReport;
		$display("Comparisons %0d mismatches %0d", testsRun, nMismatch);
		if (nMismatch == 0 && testsRun > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finalReport
	task chk(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			nMismatch++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Reader keeps the minimum frame gap before each frame
	task snd(input logic [7:0] q[$], input logic ok);
		repeat (20) @(posedge core_clk);
		foreach (q[i]) begin
			rxByte <= {q[i], i == q.size() - 1, ok};
			rxValid <= 1'b1;
			@(posedge core_clk);
		end
		rxValid <= 1'b0;
	endtask : snd
	task rcv(input int len);
		int k;
		r = {};
		for (k = 0; k < 400; k++) begin
			@(posedge core_clk);
			#1;
			if (txValid === 1'b1) r.push_back(txByte.data);
			if (txValid === 1'b1 && txByte.last === 1'b1) break;
		end
		if (k == 400) begin
			nMismatch++;
			finalReport();
		end
		chk(8'(r.size()), 8'(len));
	endtask : rcv
	task nib(input logic [3:0] e);
		rcv(1);
		chk({4'h0, r[0][3:0]}, {4'h0, e});
	endtask : nib
	task pulse(input logic fld);
		@(posedge core_clk);
		fieldReset <= fld;
		unselect <= !fld;
		@(posedge core_clk);
		fieldReset <= 1'b0;
		unselect <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask : pulse
	task auth(input logic [7:0] code);
		snd('{code, 8'h00}, 1'b1);
		rcv(4);
		snd('{8'h10, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65, 8'h76, 8'h87}, 1'b1);
		rcv(4);
		chk({7'h0, authKeyB}, {7'h0, code[0]});
		chk(authBlock, 8'h00);
	endtask : auth
	// ****
	// Scenarios
	// ****
	task scnRead;
		auth(8'h60);
		snd('{8'h30, 8'h00}, 1'b1);
		rcv(16);
		chk(r[`CCI_STATUS_BYTE], `CCI_STATUS_STRONG);
		snd('{8'h30, 8'hFF}, 1'b1);
		rcv(16);
		chk(r[0], 8'hFF);
		snd('{8'h30}, 1'b1);
		nib(`CCI_NAK);
		snd('{8'h30, 8'h00}, 1'b0);
		nib(`CCI_NAK);
	endtask : scnRead
	task scnWrite;
		auth(8'h60);
		d = {};
		for (int i = 0; i < 16; i++) d.push_back(8'(i * 17));
		snd('{8'hA0, 8'h02}, 1'b1);
		nib(`CCI_ACK);
		snd(d, 1'b1);
		nib(`CCI_ACK);
		snd('{8'h30, 8'h02}, 1'b1);
		rcv(16);
		foreach (d[i]) chk(r[i], d[i]);
	endtask : scnWrite
	task scnConfig;
		auth(8'h60);
		snd('{8'h43, 8'h00}, 1'b1);
		nib(`CCI_ACK);
		chk({7'h0, strongMod}, 8'h01);
		snd('{8'h30, 8'h00}, 1'b1);
		rcv(16);
		chk(r[`CCI_STATUS_BYTE], `CCI_STATUS_NORMAL);
		snd('{8'h43, 8'h01}, 1'b1);
		nib(`CCI_ACK);
		snd('{8'h43, 8'h00}, 1'b1);
		nib(`CCI_ACK);
		pulse(1'b0);
		chk({7'h0, strongMod}, 8'h00);
		auth(8'h61);
		snd('{8'h43, 8'h01}, 1'b1);
		nib(`CCI_NAK);
		pulse(1'b1);
		chk({7'h0, strongMod}, 8'h00);
	endtask : scnConfig
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		chk({7'h0, strongMod}, 8'h01);
		scnRead();
		scnWrite();
		scnConfig();
		finalReport();
	end
endmodule : testbench
